// ==== src/afc_ctrl.v ====
// Controller that drives an external asynchronous nine-bit FIFO through its pins.
// Assumes the device flags are already synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "afc_defs.vh"

module afc_ctrl #(
    parameter integer PULSE_CYC = `AFC_PULSE_CYC,
    parameter integer RECOVERY_CYC = `AFC_RECOVERY_CYC,
    parameter integer ACCESS_CYC = `AFC_ACCESS_CYC
) (
    input wire sys_clk,
    input wire rst_b,
    // User side
    input wire wr_req,
    input wire [`AFC_DATA_W-1:0] wr_data,
    output reg wr_busy_q,
    output reg wr_done_q,
    output reg wr_refused_q,
    input wire rd_req,
    output reg [`AFC_DATA_W-1:0] rd_data_q,
    output reg rd_valid_q,
    output reg rd_refused_q,
    input wire replay_req,
    input wire clear_req,
    output reg ctl_busy_q,
    output reg empty_q,
    output reg full_q,
    output reg half_q,
    // Device pins
    output reg wr_strobe_n_q,
    output reg [`AFC_DATA_W-1:0] dev_data_q,
    output reg rd_strobe_n_q,
    input wire [`AFC_DATA_W-1:0] dev_q,
    output reg replay_input_n_q,
    output reg master_clear_n_q,
    input wire empty_flag_n,
    input wire full_flag_n,
    input wire half_level_flag_n
);

    localparam [7:0] PULSE_C = PULSE_CYC[7:0];
    localparam [7:0] RECOV_C = RECOVERY_CYC[7:0];
    localparam [7:0] ACCESS_C = ACCESS_CYC[7:0];

    function [7:0] dec;
        input [7:0] v;
        begin
            dec = (v == 8'h00) ? 8'h00 : v - 8'h01;
        end
    endfunction

    // ----------------------------------------------------------------
    // Write side
    // ----------------------------------------------------------------
    reg [2:0] wst_q;
    reg [7:0] wcnt_q;
    // Write engine stands still while a replay or clear holds the strobes
    wire ctl_active = ctl_busy_q;

    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wst_q <= `AFC_ST_IDLE;
            wcnt_q <= 8'h00;
            wr_strobe_n_q <= 1'b1;
            dev_data_q <= {`AFC_DATA_W{1'b0}};
            wr_busy_q <= 1'b0;
            wr_done_q <= 1'b0;
            wr_refused_q <= 1'b0;
        end
        else
        begin
            wr_done_q <= 1'b0;
            wr_refused_q <= 1'b0;
            wcnt_q <= dec(wcnt_q);
            case (wst_q)
                `AFC_ST_IDLE:
                begin
                    if (wr_req && !ctl_active && !clear_req && !replay_req)
                    begin
                        if (!full_flag_n)
                            wr_refused_q <= 1'b1;
                        else
                        begin
                            dev_data_q <= wr_data;
                            wr_strobe_n_q <= 1'b0;
                            wr_busy_q <= 1'b1;
                            wcnt_q <= PULSE_C - 8'h01;
                            wst_q <= `AFC_ST_PULSE;
                        end
                    end
                end
                `AFC_ST_PULSE:
                begin
                    if (wcnt_q == 8'h00)
                    begin
                        // Data held across the rising edge satisfies hold time
                        wr_strobe_n_q <= 1'b1;
                        wcnt_q <= RECOV_C - 8'h01;
                        wst_q <= `AFC_ST_RECOVER;
                    end
                end
                `AFC_ST_RECOVER:
                begin
                    if (wcnt_q == 8'h00)
                    begin
                        wr_busy_q <= 1'b0;
                        wr_done_q <= 1'b1;
                        wst_q <= `AFC_ST_IDLE;
                    end
                end
                default:
                begin
                    wst_q <= `AFC_ST_IDLE;
                    wr_strobe_n_q <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read side, independent of writes
    // ----------------------------------------------------------------
    reg [2:0] rst_q;
    reg [7:0] rcnt_q;

    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_q <= `AFC_ST_IDLE;
            rcnt_q <= 8'h00;
            rd_strobe_n_q <= 1'b1;
            rd_data_q <= {`AFC_DATA_W{1'b0}};
            rd_valid_q <= 1'b0;
            rd_refused_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= 1'b0;
            rd_refused_q <= 1'b0;
            rcnt_q <= dec(rcnt_q);
            case (rst_q)
                `AFC_ST_IDLE:
                begin
                    if (rd_req && !ctl_active && !clear_req && !replay_req)
                    begin
                        if (!empty_flag_n)
                            rd_refused_q <= 1'b1;
                        else
                        begin
                            rd_strobe_n_q <= 1'b0;
                            rcnt_q <= ACCESS_C - 8'h01;
                            rst_q <= `AFC_ST_PULSE;
                        end
                    end
                end
                `AFC_ST_PULSE:
                begin
                    if (rcnt_q == 8'h00)
                    begin
                        // Sample before release; the bus floats once the strobe rises
                        rd_data_q <= dev_q;
                        rd_valid_q <= 1'b1;
                        rd_strobe_n_q <= 1'b1;
                        rcnt_q <= RECOV_C - 8'h01;
                        rst_q <= `AFC_ST_RECOVER;
                    end
                end
                `AFC_ST_RECOVER:
                begin
                    if (rcnt_q == 8'h00)
                        rst_q <= `AFC_ST_IDLE;
                end
                default:
                begin
                    rst_q <= `AFC_ST_IDLE;
                    rd_strobe_n_q <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Replay and master clear
    // ----------------------------------------------------------------
    reg [2:0] cst_q;
    reg [7:0] ccnt_q;
    reg cop_q;
    wire strobes_idle = (wst_q == `AFC_ST_IDLE) && (rst_q == `AFC_ST_IDLE) &&
        wr_strobe_n_q && rd_strobe_n_q;

    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cst_q <= `AFC_ST_IDLE;
            ccnt_q <= 8'h00;
            cop_q <= 1'b0;
            ctl_busy_q <= 1'b0;
            replay_input_n_q <= 1'b1;
            master_clear_n_q <= 1'b1;
        end
        else
        begin
            ccnt_q <= dec(ccnt_q);
            case (cst_q)
                `AFC_ST_IDLE:
                begin
                    // Wait for both strobes high before pulsing
                    if ((clear_req || replay_req) && strobes_idle)
                    begin
                        ctl_busy_q <= 1'b1;
                        cop_q <= clear_req;
                        if (clear_req)
                            master_clear_n_q <= 1'b0;
                        else
                            replay_input_n_q <= 1'b0;
                        ccnt_q <= PULSE_C - 8'h01;
                        cst_q <= `AFC_ST_PULSE;
                    end
                end
                `AFC_ST_PULSE:
                begin
                    if (ccnt_q == 8'h00)
                    begin
                        master_clear_n_q <= 1'b1;
                        replay_input_n_q <= 1'b1;
                        // Flags settle only after recovery, so hold off strobes
                        ccnt_q <= RECOV_C - 8'h01;
                        cst_q <= `AFC_ST_RECOVER;
                    end
                end
                `AFC_ST_RECOVER:
                begin
                    if (ccnt_q == 8'h00)
                    begin
                        ctl_busy_q <= 1'b0;
                        cst_q <= `AFC_ST_IDLE;
                    end
                end
                default:
                begin
                    cst_q <= `AFC_ST_IDLE;
                    ctl_busy_q <= 1'b0;
                    master_clear_n_q <= 1'b1;
                    replay_input_n_q <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Flag mirrors
    // ----------------------------------------------------------------
    // Half level is only meaningful when the device is not depth-cascaded
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            empty_q <= 1'b1;
            full_q <= 1'b0;
            half_q <= 1'b0;
        end
        else
        begin
            empty_q <= !empty_flag_n;
            full_q <= !full_flag_n;
            half_q <= !half_level_flag_n;
        end
    end

endmodule
`default_nettype wire

// ==== src/afc_defs.vh ====
// Constants for the controller that drives an asynchronous nine-bit FIFO device.
// Assumes the including file runs on a 200 MHz system clock.
`ifndef AFC_DEFS_VH
`define AFC_DEFS_VH

`define AFC_DATA_W 9
`define AFC_CLK_PERIOD_NS 5
// Strobe timing in ns, fastest grade
`define AFC_PULSE_NS 20
`define AFC_RECOVERY_NS 10
`define AFC_ACCESS_NS 20
`define AFC_PULSE_CYC ((`AFC_PULSE_NS + `AFC_CLK_PERIOD_NS - 1) / `AFC_CLK_PERIOD_NS)
`define AFC_RECOVERY_CYC ((`AFC_RECOVERY_NS + `AFC_CLK_PERIOD_NS - 1) / `AFC_CLK_PERIOD_NS)
`define AFC_ACCESS_CYC ((`AFC_ACCESS_NS + `AFC_CLK_PERIOD_NS - 1) / `AFC_CLK_PERIOD_NS)

`define AFC_ST_IDLE 3'h0
`define AFC_ST_PULSE 3'h1
`define AFC_ST_RECOVER 3'h2

`define AFC_OP_WRITE 2'h0
`define AFC_OP_READ 2'h1
`define AFC_OP_REPLAY 2'h2
`define AFC_OP_CLEAR 2'h3

`endif

// ==== bench/afc_props.sv ====
// Concurrent checks on the pin and user side of the FIFO controller.
// Assumes default strobe timing: four-cycle pulses, flags mirrored after one cycle.
`timescale 1ns/1ps
`default_nettype none
module afc_props (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic wr_strobe_n_q,
    input wire logic rd_strobe_n_q,
    input wire logic replay_input_n_q,
    input wire logic master_clear_n_q,
    input wire logic empty_flag_n,
    input wire logic full_flag_n,
    input wire logic half_level_flag_n,
    input wire logic empty_q,
    input wire logic full_q,
    input wire logic half_q,
    input wire logic rd_valid_q,
    input wire logic wr_done_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    chk_wr_pulse_len: assert property ($fell(wr_strobe_n_q) |->
        !wr_strobe_n_q [*4] ##1 wr_strobe_n_q) else $error("write pulse length wrong");
    chk_rd_pulse_len: assert property ($fell(rd_strobe_n_q) |->
        !rd_strobe_n_q [*4] ##1 rd_strobe_n_q) else $error("read pulse length wrong");
    chk_wr_not_full: assert property ($fell(wr_strobe_n_q) |-> $past(full_flag_n))
        else $error("write strobed into full device");
    chk_rd_not_empty: assert property ($fell(rd_strobe_n_q) |-> $past(empty_flag_n))
        else $error("read strobed on empty device");
    chk_replay_strobes_idle: assert property (!replay_input_n_q |->
        wr_strobe_n_q && rd_strobe_n_q) else $error("strobe low during replay");
    chk_clear_strobes_idle: assert property (!master_clear_n_q |->
        wr_strobe_n_q && rd_strobe_n_q) else $error("strobe low during clear");
    chk_flag_mirror: assert property ($past(rst_b) |-> {empty_q, full_q, half_q} ==
        ~$past({empty_flag_n, full_flag_n, half_level_flag_n})) else $error("flag mirror wrong");
    chk_rd_valid_time: assert property ($fell(rd_strobe_n_q) |-> ##4 rd_valid_q)
        else $error("read data not delivered in time");
    chk_wr_done_time: assert property ($fell(wr_strobe_n_q) |-> ##6 wr_done_q)
        else $error("write done not on time");
    chk_replay_len: assert property ($fell(replay_input_n_q) |->
        !replay_input_n_q [*4] ##1 replay_input_n_q) else $error("replay pulse length wrong");
    cov_full: cover property (full_q);
    cov_replay: cover property ($fell(replay_input_n_q));
    cov_clear: cover property ($fell(master_clear_n_q));
endmodule
`default_nettype wire

// ==== bench/afc_dev_model.sv ====
// Behavioural model of the asynchronous nine-bit FIFO device.
// Assumes its strobes come from the controller; depth is shrunk to reach full quickly.
`timescale 1ns/1ps
`default_nettype none
module afc_dev_model #(
    parameter integer DEPTH = 8
) (
    input wire logic wr_strobe_n_q,
    input wire logic rd_strobe_n_q,
    input wire logic replay_input_n_q,
    input wire logic master_clear_n_q,
    input wire logic [8:0] dev_data_q,
    output logic [8:0] dev_q,
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic half_level_flag_n
);
    logic [8:0] mem [DEPTH];
    logic [8:0] out_q = 9'h000;
    int wp = 0;
    int rp = 0;
    int cnt = 0;
    always @(posedge wr_strobe_n_q)
        if (cnt < DEPTH)
        begin
            mem[wp] = dev_data_q;
            wp = (wp + 1) % DEPTH;
            cnt++;
        end
    always @(negedge rd_strobe_n_q)
        if (cnt > 0)
        begin
            out_q = mem[rp];
            rp = (rp + 1) % DEPTH;
            cnt--;
        end
    // Replay after a full wrap would see zero words; tests keep below depth
    always @(negedge replay_input_n_q)
    begin
        rp = 0;
        cnt = wp;
    end
    always @(negedge master_clear_n_q)
    begin
        wp = 0;
        rp = 0;
        cnt = 0;
    end
    // Released bus shows inverted data so a late sample cannot pass
    assign dev_q = rd_strobe_n_q ? ~out_q : out_q;
    assign empty_flag_n = (cnt != 0);
    assign full_flag_n = (cnt != DEPTH);
    // Standalone model: the pin always carries the half level, never the cascade output
    assign half_level_flag_n = !(cnt > DEPTH / 2);
endmodule
`default_nettype wire

// ==== bench/afc_ctrl_tb.sv ====
// Self-checking bench for the FIFO controller against the device model.
// Assumes default controller timing and a model depth of eight words.
`timescale 1ns/1ps
`default_nettype none
module afc_ctrl_tb;
    logic sys_clk, rst_b, wr_req, rd_req, replay_req, clear_req;
    logic [8:0] wr_data, rd_data_q, dev_data_q, dev_q;
    logic wr_busy_q, wr_done_q, wr_refused_q, rd_valid_q, rd_refused_q, ctl_busy_q;
    logic empty_q, full_q, half_q, wr_strobe_n_q, rd_strobe_n_q, replay_input_n_q;
    logic master_clear_n_q, empty_flag_n, full_flag_n, half_level_flag_n;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    afc_ctrl afc_ctrl_i (.*);
    afc_dev_model #(.DEPTH(8)) afc_dev_model_i (.*);
    initial
    begin
        sys_clk = 0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            bad_count++;
            finish_test();
        end
    end
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Transfer, replay and clear tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [8:0] d, input logic refuse);
        @(negedge sys_clk);
        wr_req = 1;
        wr_data = d;
        @(negedge sys_clk);
        wr_req = 0;
        // Refusal pulse stands one cycle only, so look right after the taking edge
        check(wr_refused_q, refuse);
        check(wr_busy_q, !refuse);
        @(negedge sys_clk);
        for (int i = 0; i < 12 && !refuse && wr_done_q !== 1'b1; i++)
            @(negedge sys_clk);
        check(wr_done_q, !refuse);
        check(wr_busy_q, 0);
    endtask
    task automatic rd(input logic [8:0] exp, input logic refuse);
        @(negedge sys_clk);
        rd_req = 1;
        @(negedge sys_clk);
        rd_req = 0;
        check(rd_refused_q, refuse);
        @(negedge sys_clk);
        for (int i = 0; i < 12 && !refuse && rd_valid_q !== 1'b1; i++)
            @(negedge sys_clk);
        check(rd_valid_q, !refuse);
        if (!refuse)
            check(rd_data_q, exp);
        // Read engine needs its recovery time before the next request
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic ctl(input logic clr);
        @(negedge sys_clk);
        clear_req = clr;
        replay_req = !clr;
        @(negedge sys_clk);
        clear_req = 0;
        replay_req = 0;
        @(negedge sys_clk);
        check(clr ? master_clear_n_q : replay_input_n_q, 0);
        check(ctl_busy_q, 1);
        repeat (7) @(negedge sys_clk);
        check(ctl_busy_q, 0);
    endtask
    initial
    begin
        {rst_b, wr_req, rd_req, replay_req, clear_req, wr_data} = 0;
        repeat (4) @(negedge sys_clk);
        rst_b = 1;
        ctl(1);
        check({empty_q, full_q, half_q}, 3'b100);
        $display("clear test done");
        for (int i = 0; i < 8; i++)
        begin
            wr(9'h1a0 + i, 0);
            check(half_q, i >= 4);
        end
        check(full_q, 1);
        wr(9'h0ff, 0 + 1);
        $display("fill test done");
        for (int i = 0; i < 8; i++)
        begin
            rd(9'h1a0 + i, 0);
            check(half_q, i < 3);
        end
        check(empty_q, 1);
        rd(9'h000, 1);
        $display("drain test done");
        for (int i = 0; i < 3; i++)
            wr(9'h055 + i, 0);
        rd(9'h055, 0);
        ctl(0);
        check(empty_q, 0);
        for (int i = 0; i < 3; i++)
            rd(9'h055 + i, 0);
        $display("replay test done");
        finish_test();
    end
endmodule
bind afc_ctrl afc_props afc_props_i (.*);
`default_nettype wire
